/* design/pmux_pkg.sv */
// constants, function codes and carrier types of the pin function multiplexer
// assumes one 10 MHz clock and that all pad inputs are synchronous to it
package pmux_pkg;

  // ***************
  // pin indices
  // ***************
  localparam int PMUX_NPINS = 12;
  localparam int PIN_TCK = 0;
  localparam int PIN_RST = 1;
  localparam int PIN_C0 = 2;
  localparam int PIN_C1 = 3;
  localparam int PIN_C2 = 4;
  localparam int PIN_F8 = 5;
  localparam int PIN_C3 = 6;
  localparam int PIN_C4 = 7;
  localparam int PIN_A7 = 8;
  localparam int PIN_A6 = 9;
  localparam int PIN_A5 = 10;
  localparam int PIN_A4 = 11;

  // ***************
  // function codes
  // ***************
  localparam int PMUX_SEL_W = 3;
  typedef logic [PMUX_SEL_W-1:0] pmux_sel_t;
  localparam pmux_sel_t FN_PRIMARY = 3'h0;
  localparam pmux_sel_t FN_PORT_D = 3'h1;
  localparam pmux_sel_t FN_CRYSTAL = 3'h1;
  localparam pmux_sel_t FN_CLKIN = 3'h2;
  localparam pmux_sel_t FN_C2_TX = 3'h1;
  localparam pmux_sel_t FN_C2_XB_TB = 3'h2;
  localparam pmux_sel_t FN_C2_XBIN = 3'h3;
  localparam pmux_sel_t FN_C2_CKOUT = 3'h4;
  localparam pmux_sel_t FN_F8_RX = 3'h1;
  localparam pmux_sel_t FN_F8_XB_TB = 3'h2;
  localparam pmux_sel_t FN_F8_CMPD = 3'h3;
  localparam pmux_sel_t FN_F8_PWM = 3'h4;
  localparam pmux_sel_t FN_C3_TA0 = 3'h1;
  localparam pmux_sel_t FN_C3_CMPA = 3'h2;
  localparam pmux_sel_t FN_C3_RX = 3'h3;
  localparam pmux_sel_t FN_C3_CLKIN1 = 3'h4;
  localparam pmux_sel_t FN_C4_TA1 = 3'h1;
  localparam pmux_sel_t FN_C4_CMPB = 3'h2;
  localparam pmux_sel_t FN_C4_XBIN = 3'h3;
  localparam pmux_sel_t FN_C4_WDOG = 3'h4;
  localparam pmux_sel_t FN_ANALOG = 3'h1;

  // ***************
  // reset values and variants
  // ***************
  localparam logic PMUX_PEN_RST = 1'b0;
  localparam pmux_sel_t PMUX_SEL_RST = 3'h0;
  localparam int PMUX_CKO_W = 3;
  localparam logic [PMUX_CKO_W-1:0] PMUX_CKO_RST = 3'h0;
  localparam logic PMUX_VAR_A = 1'b0;
  localparam logic PMUX_VAR_B = 1'b1;
  localparam int PMUX_RST_CYCLES = 16;

  // ***************
  // carriers
  // ***************
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic ana;
  } pmux_pad_t;

  typedef struct packed {
    logic serial0_tx;
    logic serial0_tx_oe;
    logic xbar_out11;
    logic xbar_out10;
    logic timer_b0_o;
    logic timer_b0_oe;
    logic timer_b1_o;
    logic timer_b1_oe;
    logic timer_a0_o;
    logic timer_a0_oe;
    logic timer_a1_o;
    logic timer_a1_oe;
    logic cmp_a_o;
    logic cmp_b_o;
    logic cmp_d_o;
    logic pwm_2x_o;
    logic pwm_2x_oe;
    logic wdog_mon_out;
    logic crystal_drive;
  } pmux_per_out_t;

  typedef struct packed {
    logic test_clock;
    logic serial0_rx;
    logic xbar_in2;
    logic xbar_in_c4;
    logic crystal_in;
    logic ext_clock_in0;
    logic ext_clock_in1;
    logic timer_b0_i;
    logic timer_b1_i;
    logic timer_a0_i;
    logic timer_a1_i;
    logic pwm_2x_i;
  } pmux_per_in_t;

endpackage

/* design/pmux_rst_seq.sv */
// internal reset sequencer of the pin function multiplexer
// assumes reset requests are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none

module pmux_rst_seq #(
  parameter int CYCLES = pmux_pkg::PMUX_RST_CYCLES
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // power-on reset, async, low
  input wire logic rst_req, // synchronous reset request
  output logic dev_rst_n // internal reset, low active
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_r;

  // count held at zero while requested, release after a fixed count
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (rst_req)
      cnt_r <= '0;
    else if (cnt_r != LAST)
      cnt_r <= cnt_r + CW'(1);
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      dev_rst_n <= 1'b0;
    else
      dev_rst_n <= (cnt_r == LAST) && !rst_req; // [RULE_04]
  end

endmodule
`default_nettype wire

/* design/pmux_top.sv */
// pin function multiplexer for twelve pads of a small controller package
// assumes pad inputs synchronous to sys_clk; pad drivers resolve o/oe/pu/ana
//
// Summary of operation
// [RULE_01] after any reset every pin carries its first-listed function.
// [RULE_02] an alternate is routed only when peripheral enable and pin select both choose it.
// [RULE_03] a low reset pin initialises the device and holds it in reset.
// [RULE_04] internal reset releases synchronously a fixed count of clocks after the pin rises.
// [RULE_05] reset pin as a port bit does not reset; only power-on, watchdog or software reset.
// [RULE_06] every pin acting as a port bit has its own input or output direction.
// [RULE_07] the test-clock pin leaves reset as test clock with its port D role off.
// [RULE_08] the reset pin leaves reset as reset input with its port D role off.
// [RULE_09] the test clock is a gated tester clock feeding test logic and the pin is pulled up.
// [RULE_10] the clock-out function drives the source chosen by the clock-out source field.
// [RULE_11] serial transmit on its pin carries transmit data, and both directions in single wire.
// [RULE_12] one mux position is crossbar output 11 on variant A, timer B channel 0 on variant B.
// [RULE_13] an analog pin feeds its converter and comparator inputs, plus converter C on B; on B only A4 feeds comparator D.
// [RULE_14] crystal, clock-input, serial, timer and analog pins leave reset as port bits.
// [RULE_15] selection registers act the cycle after a write and clear on every reset.
`timescale 1ns/1ps
`default_nettype none

module pmux_top #(
  parameter logic VARIANT = pmux_pkg::PMUX_VAR_A, // device variant
  parameter int RST_CYCLES = pmux_pkg::PMUX_RST_CYCLES, // reset release count
  parameter int NCLK = 8 // clock-out sources
) (
  input wire logic sys_clk, // system clock
  input wire logic rstn, // power-on reset, async, low
  input wire logic wdog_rst_req, // watchdog reset request
  input wire logic sw_rst_req, // software reset request
  output logic dev_rst_n, // internal reset, low active
  input wire logic cfg_wr, // write strobe for pin selection
  input wire logic [pmux_pkg::PMUX_NPINS-1:0] cfg_periph_en, // peripheral enables
  input wire pmux_pkg::pmux_sel_t [pmux_pkg::PMUX_NPINS-1:0] cfg_pin_sel, // pin selects
  input wire logic cko_wr, // write strobe for clock-out select
  input wire logic [pmux_pkg::PMUX_CKO_W-1:0] clock_out_source_field, // clock-out source
  input wire logic [NCLK-1:0] clk_src, // clock-out candidates
  input wire logic serial0_single_wire, // serial 0 single-wire mode
  input wire logic [pmux_pkg::PMUX_NPINS-1:0] gpio_out, // port output data
  input wire logic [pmux_pkg::PMUX_NPINS-1:0] gpio_dir, // port direction, 1 output
  output logic [pmux_pkg::PMUX_NPINS-1:0] gpio_in, // port input data
  input wire pmux_pkg::pmux_per_out_t per_o, // peripheral outputs
  output pmux_pkg::pmux_per_in_t per_i, // peripheral inputs
  input wire logic [pmux_pkg::PMUX_NPINS-1:0] pad_i, // pad input levels
  output pmux_pkg::pmux_pad_t [pmux_pkg::PMUX_NPINS-1:0] pad, // pad controls
  output logic [3:0] conv_a_ch_en, // converter A channels 7..4 fed
  output logic [3:0] cmp_d_in_en, // comparator D inputs 3..0 fed
  output logic [3:0] conv_c_ch_en, // converter C channels 11..8 fed
  output logic [pmux_pkg::PMUX_NPINS-1:0] alt_active, // pin runs an alternate
  output logic [pmux_pkg::PMUX_CKO_W-1:0] clock_out_select_reg // clock-out select readback
);

  localparam int N = pmux_pkg::PMUX_NPINS;

  logic [N-1:0] pen_r;
  pmux_pkg::pmux_sel_t [N-1:0] sel_r;
  pmux_pkg::pmux_sel_t [N-1:0] fn;
  pmux_pkg::pmux_pad_t [N-1:0] pad_nxt;
  pmux_pkg::pmux_per_in_t per_nxt;
  logic [3:0] ca_nxt;
  logic [3:0] cd_nxt;
  logic [3:0] cc_nxt;
  logic rst_pin_req;
  logic cko;
  logic var_b;

  assign var_b = (VARIANT == pmux_pkg::PMUX_VAR_B);

  // ***************
  // reset
  // ***************
  // pin reset only counts while the pin holds its reset role
  assign rst_pin_req = (fn[pmux_pkg::PIN_RST] == pmux_pkg::FN_PRIMARY)
    && !pad_i[pmux_pkg::PIN_RST]; // [RULE_03] [RULE_05]

  pmux_rst_seq #(
    .CYCLES(RST_CYCLES)
  ) u_rst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .rst_req(rst_pin_req || wdog_rst_req || sw_rst_req), // [RULE_05]
    .dev_rst_n(dev_rst_n)
  );

  // ***************
  // selection registers
  // ***************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pen_r <= {N{pmux_pkg::PMUX_PEN_RST}};
      sel_r <= {N{pmux_pkg::PMUX_SEL_RST}};
    end
    else if (!dev_rst_n)
    begin
      pen_r <= {N{pmux_pkg::PMUX_PEN_RST}}; // [RULE_15] [RULE_01]
      sel_r <= {N{pmux_pkg::PMUX_SEL_RST}};
    end
    else if (cfg_wr)
    begin
      pen_r <= cfg_periph_en; // [RULE_15]
      sel_r <= cfg_pin_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      clock_out_select_reg <= pmux_pkg::PMUX_CKO_RST;
    else if (!dev_rst_n)
      clock_out_select_reg <= pmux_pkg::PMUX_CKO_RST;
    else if (cko_wr)
      clock_out_select_reg <= clock_out_source_field;
  end

  assign cko = (32'(clock_out_select_reg) < NCLK)
    ? clk_src[clock_out_select_reg] : 1'b0; // [RULE_10]

  // effective function per pin
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_fn
      assign fn[g] = pen_r[g] ? sel_r[g] : pmux_pkg::FN_PRIMARY; // [RULE_02]
      assign alt_active[g] = (fn[g] != pmux_pkg::FN_PRIMARY);
    end
  endgenerate

  // ***************
  // pad routing
  // ***************
  always_comb
  begin
    per_nxt = '0;
    ca_nxt = 4'h0;
    cd_nxt = 4'h0;
    cc_nxt = 4'h0;
    for (int i = 0; i < N; i++)
    begin
      pad_nxt[i] = '0;
      // port bit role: primary on most pins, alternate on the first two
      if ((i == pmux_pkg::PIN_TCK || i == pmux_pkg::PIN_RST)
          ? (fn[i] == pmux_pkg::FN_PORT_D) : (fn[i] == pmux_pkg::FN_PRIMARY))
      begin
        pad_nxt[i].o = gpio_out[i]; // [RULE_06] [RULE_14]
        pad_nxt[i].oe = gpio_dir[i]; // [RULE_06]
      end
    end

    // test clock pin
    if (fn[pmux_pkg::PIN_TCK] == pmux_pkg::FN_PRIMARY)
    begin
      pad_nxt[pmux_pkg::PIN_TCK].pu = 1'b1; // [RULE_09] [RULE_07]
      per_nxt.test_clock = pad_i[pmux_pkg::PIN_TCK]; // [RULE_09]
    end
    // reset pin keeps its pull-up while in reset role
    if (fn[pmux_pkg::PIN_RST] == pmux_pkg::FN_PRIMARY)
      pad_nxt[pmux_pkg::PIN_RST].pu = 1'b1; // [RULE_08]

    // crystal input or external clock 0
    case (fn[pmux_pkg::PIN_C0])
      pmux_pkg::FN_CRYSTAL: per_nxt.crystal_in = pad_i[pmux_pkg::PIN_C0];
      pmux_pkg::FN_CLKIN: per_nxt.ext_clock_in0 = pad_i[pmux_pkg::PIN_C0];
      default: ;
    endcase

    // crystal drive
    if (fn[pmux_pkg::PIN_C1] == pmux_pkg::FN_CRYSTAL)
    begin
      pad_nxt[pmux_pkg::PIN_C1].o = per_o.crystal_drive;
      pad_nxt[pmux_pkg::PIN_C1].oe = 1'b1;
    end

    // serial transmit, crossbar or timer, crossbar in, clock out
    case (fn[pmux_pkg::PIN_C2])
      pmux_pkg::FN_C2_TX:
      begin
        pad_nxt[pmux_pkg::PIN_C2].o = per_o.serial0_tx; // [RULE_11]
        pad_nxt[pmux_pkg::PIN_C2].oe = serial0_single_wire ? per_o.serial0_tx_oe : 1'b1;
        if (serial0_single_wire)
          per_nxt.serial0_rx = pad_i[pmux_pkg::PIN_C2]; // [RULE_11]
      end
      pmux_pkg::FN_C2_XB_TB:
      begin
        if (var_b)
        begin
          pad_nxt[pmux_pkg::PIN_C2].o = per_o.timer_b0_o; // [RULE_12]
          pad_nxt[pmux_pkg::PIN_C2].oe = per_o.timer_b0_oe;
          per_nxt.timer_b0_i = pad_i[pmux_pkg::PIN_C2];
        end
        else
        begin
          pad_nxt[pmux_pkg::PIN_C2].o = per_o.xbar_out11; // [RULE_12]
          pad_nxt[pmux_pkg::PIN_C2].oe = 1'b1;
        end
      end
      pmux_pkg::FN_C2_XBIN: per_nxt.xbar_in2 = pad_i[pmux_pkg::PIN_C2];
      pmux_pkg::FN_C2_CKOUT:
      begin
        pad_nxt[pmux_pkg::PIN_C2].o = cko; // [RULE_10]
        pad_nxt[pmux_pkg::PIN_C2].oe = 1'b1;
      end
      default: ;
    endcase

    // serial receive, crossbar or timer, comparator D, pwm
    case (fn[pmux_pkg::PIN_F8])
      pmux_pkg::FN_F8_RX: per_nxt.serial0_rx = pad_i[pmux_pkg::PIN_F8];
      pmux_pkg::FN_F8_XB_TB:
      begin
        pad_nxt[pmux_pkg::PIN_F8].o = var_b ? per_o.timer_b1_o : per_o.xbar_out10;
        pad_nxt[pmux_pkg::PIN_F8].oe = var_b ? per_o.timer_b1_oe : 1'b1;
        per_nxt.timer_b1_i = var_b & pad_i[pmux_pkg::PIN_F8];
      end
      pmux_pkg::FN_F8_CMPD:
      begin
        pad_nxt[pmux_pkg::PIN_F8].o = per_o.cmp_d_o;
        pad_nxt[pmux_pkg::PIN_F8].oe = 1'b1;
      end
      pmux_pkg::FN_F8_PWM:
      begin
        // pwm output exists only on variant A
        pad_nxt[pmux_pkg::PIN_F8].o = per_o.pwm_2x_o;
        pad_nxt[pmux_pkg::PIN_F8].oe = !var_b & per_o.pwm_2x_oe;
        per_nxt.pwm_2x_i = !var_b & pad_i[pmux_pkg::PIN_F8];
      end
      default: ;
    endcase

    // timer A0, comparator A, serial receive, external clock 1
    case (fn[pmux_pkg::PIN_C3])
      pmux_pkg::FN_C3_TA0:
      begin
        pad_nxt[pmux_pkg::PIN_C3].o = per_o.timer_a0_o;
        pad_nxt[pmux_pkg::PIN_C3].oe = per_o.timer_a0_oe;
        per_nxt.timer_a0_i = pad_i[pmux_pkg::PIN_C3];
      end
      pmux_pkg::FN_C3_CMPA:
      begin
        pad_nxt[pmux_pkg::PIN_C3].o = per_o.cmp_a_o;
        pad_nxt[pmux_pkg::PIN_C3].oe = 1'b1;
      end
      pmux_pkg::FN_C3_RX: per_nxt.serial0_rx = pad_i[pmux_pkg::PIN_C3];
      pmux_pkg::FN_C3_CLKIN1: per_nxt.ext_clock_in1 = pad_i[pmux_pkg::PIN_C3];
      default: ;
    endcase

    // timer A1, comparator B, crossbar in, watchdog monitor
    case (fn[pmux_pkg::PIN_C4])
      pmux_pkg::FN_C4_TA1:
      begin
        pad_nxt[pmux_pkg::PIN_C4].o = per_o.timer_a1_o;
        pad_nxt[pmux_pkg::PIN_C4].oe = per_o.timer_a1_oe;
        per_nxt.timer_a1_i = pad_i[pmux_pkg::PIN_C4];
      end
      pmux_pkg::FN_C4_CMPB:
      begin
        pad_nxt[pmux_pkg::PIN_C4].o = per_o.cmp_b_o;
        pad_nxt[pmux_pkg::PIN_C4].oe = 1'b1;
      end
      pmux_pkg::FN_C4_XBIN: per_nxt.xbar_in_c4 = pad_i[pmux_pkg::PIN_C4];
      pmux_pkg::FN_C4_WDOG:
      begin
        pad_nxt[pmux_pkg::PIN_C4].o = per_o.wdog_mon_out;
        pad_nxt[pmux_pkg::PIN_C4].oe = 1'b1;
      end
      default: ;
    endcase

    // analog pins A4..A7 map to bit 0..3 of each analog enable
    for (int k = 0; k < 4; k++)
    begin
      if (fn[pmux_pkg::PIN_A4 - k] == pmux_pkg::FN_ANALOG)
      begin
        pad_nxt[pmux_pkg::PIN_A4 - k].ana = 1'b1;
        ca_nxt[k] = 1'b1; // [RULE_13]
        // variant B drops comparator D on A5..A7 but keeps it on A4
        cd_nxt[k] = !var_b || (k == 0); // [RULE_13]
        cc_nxt[k] = var_b; // [RULE_13]
      end
    end
  end

  // ***************
  // output registers
  // ***************
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pad <= '0;
      per_i <= '0;
      conv_a_ch_en <= 4'h0;
      cmp_d_in_en <= 4'h0;
      conv_c_ch_en <= 4'h0;
    end
    else
    begin
      pad <= pad_nxt;
      per_i <= per_nxt;
      conv_a_ch_en <= ca_nxt;
      cmp_d_in_en <= cd_nxt;
      conv_c_ch_en <= cc_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      gpio_in <= '0;
    else
      gpio_in <= pad_i; // [RULE_06]
  end

endmodule
`default_nettype wire

/* tb/pmux_top_checker.sv */
// port assertions for the pin function multiplexer
// assumes the bind below attaches it to every pmux_top instance
`timescale 1ns/1ps
`default_nettype none

module pmux_top_checker #(
  parameter logic VARIANT = 1'b0,
  parameter int RST_CYCLES = 16
) (
  input wire logic sys_clk, // clock
  input wire logic rstn, // async reset, low
  input wire logic wdog_rst_req, // watchdog request
  input wire logic sw_rst_req, // software request
  input wire logic dev_rst_n, // internal reset
  input wire logic cfg_wr, // select strobe
  input wire logic [11:0] cfg_periph_en, // enables
  input wire pmux_pkg::pmux_sel_t [11:0] cfg_pin_sel, // selects
  input wire logic cko_wr, // clock-out strobe
  input wire logic [2:0] clock_out_source_field, // clock-out source
  input wire logic [11:0] gpio_out, // port data
  input wire logic [11:0] gpio_dir, // port direction
  input wire logic [11:0] gpio_in, // port input
  input wire logic [11:0] pad_i, // pad levels
  input wire pmux_pkg::pmux_pad_t [11:0] pad, // pad controls
  input wire logic [3:0] conv_a_ch_en, // converter A
  input wire logic [3:0] cmp_d_in_en, // comparator D
  input wire logic [3:0] conv_c_ch_en, // converter C
  input wire logic [11:0] alt_active, // alternate on
  input wire logic [2:0] clock_out_select_reg // source readback
);
  // ********
  // checks
  // ********
  logic [11:0] want_alt;
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      want_alt[i] = cfg_periph_en[i] && (cfg_pin_sel[i] != 3'h0);
  end
  // ********

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // first edge skipped: flops may not have seen the async reset before it
  a_in_reset: assert property (disable iff (1'b0)
    !rstn && $past(!rstn) |-> !dev_rst_n && alt_active == 12'h000 && pad == 48'h0 &&
    conv_a_ch_en == 4'h0)
    else $error("outputs not cleared in reset");
  a_release_late: assert property ($rose(dev_rst_n) |-> $past(rstn, RST_CYCLES + 1))
    else $error("internal reset released early");
  a_release_bound: assert property ($rose(rstn) |-> ##[1:40] dev_rst_n)
    else $error("internal reset never released");
  a_pin_reset: assert property (
    !pad_i[1] && !alt_active[1] |-> ##[1:3] !dev_rst_n)
    else $error("reset pin ignored");
  a_soft_reset: assert property ((sw_rst_req || wdog_rst_req) |-> ##[1:2] !dev_rst_n)
    else $error("request reset ignored");
  a_write_taken: assert property (
    dev_rst_n && cfg_wr |=> alt_active == $past(want_alt))
    else $error("selection not taken");
  a_write_holds: assert property (
    dev_rst_n && !cfg_wr |=> alt_active == $past(alt_active))
    else $error("selection changed without write");
  a_internal_clear: assert property (!dev_rst_n |=> alt_active == 12'h000)
    else $error("selection kept over reset");
  a_tck_role: assert property (
    $past(rstn) && !$past(alt_active[0]) |-> pad[0].pu && !pad[0].oe)
    else $error("test clock pad wrong");
  a_rst_role: assert property (
    $past(rstn) && !$past(alt_active[1]) |-> pad[1].pu && !pad[1].oe)
    else $error("reset pad wrong");
  a_port_input: assert property ($past(rstn) |-> gpio_in == $past(pad_i))
    else $error("port input wrong");
  a_cko_load: assert property (
    dev_rst_n && cko_wr |=> clock_out_select_reg == $past(clock_out_source_field))
    else $error("clock-out select not taken");
  for (genvar i = 2; i < 12; i++)
  begin : g_port
    a_port_path: assert property (
      $past(rstn) && !$past(alt_active[i]) |->
      pad[i].o == $past(gpio_out[i]) && pad[i].oe == $past(gpio_dir[i]))
      else $error("port pad path wrong");
  end
  for (genvar k = 0; k < 4; k++)
  begin : g_ana
    a_analog_feed: assert property (
      $past(rstn) |-> conv_a_ch_en[k] == $past(alt_active[11-k]) &&
      cmp_d_in_en[k] == ($past(alt_active[11-k]) && (k == 0 || !VARIANT)) &&
      conv_c_ch_en[k] == ($past(alt_active[11-k]) && VARIANT))
      else $error("analog routing wrong");
  end
endmodule

bind pmux_top pmux_top_checker #(.VARIANT(VARIANT), .RST_CYCLES(RST_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .wdog_rst_req(wdog_rst_req), .sw_rst_req(sw_rst_req),
  .dev_rst_n(dev_rst_n), .cfg_wr(cfg_wr), .cfg_periph_en(cfg_periph_en),
  .cfg_pin_sel(cfg_pin_sel), .cko_wr(cko_wr), .clock_out_source_field(clock_out_source_field),
  .gpio_out(gpio_out), .gpio_dir(gpio_dir), .gpio_in(gpio_in), .pad_i(pad_i), .pad(pad),
  .conv_a_ch_en(conv_a_ch_en), .cmp_d_in_en(cmp_d_in_en), .conv_c_ch_en(conv_c_ch_en),
  .alt_active(alt_active), .clock_out_select_reg(clock_out_select_reg));

`default_nettype wire

/* tb/pin_function_mux_test.sv */
// self-checking bench for the pin function multiplexer, both variants side by side
// assumes pmux_top and its bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module pin_function_mux_test;
  localparam int RSTC = 2;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic wdog_rst_req = 1'b0;
  logic sw_rst_req = 1'b0;
  logic cfg_wr = 1'b0;
  logic cko_wr = 1'b0;
  logic sw1 = 1'b0;
  logic [11:0] pen = 12'h000;
  logic [35:0] sel = 36'h0;
  logic [2:0] cks = 3'h0;
  logic [7:0] clk_src = 8'h00;
  logic [11:0] gout = 12'h000;
  logic [11:0] gdir = 12'h000;
  logic [11:0] pad_i = 12'h002;
  pmux_pkg::pmux_per_out_t per_o = '0;
  wire dev_rst_n [2];
  wire [11:0] gpio_in [2];
  wire [11:0] alt [2];
  wire pmux_pkg::pmux_per_in_t per_i [2];
  wire pmux_pkg::pmux_pad_t [11:0] pad [2];
  wire [3:0] ca [2];
  wire [3:0] cd [2];
  wire [3:0] cc [2];
  wire [2:0] ckr [2];
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  for (genvar v = 0; v < 2; v++)
  begin : g_var
    pmux_top #(.VARIANT(v == 1), .RST_CYCLES(RSTC)) DUT (
      .sys_clk(sys_clk), .rstn(rstn), .wdog_rst_req(wdog_rst_req), .sw_rst_req(sw_rst_req),
      .dev_rst_n(dev_rst_n[v]), .cfg_wr(cfg_wr), .cfg_periph_en(pen), .cfg_pin_sel(sel),
      .cko_wr(cko_wr), .clock_out_source_field(cks), .clk_src(clk_src),
      .serial0_single_wire(sw1), .gpio_out(gout), .gpio_dir(gdir), .gpio_in(gpio_in[v]),
      .per_o(per_o), .per_i(per_i[v]), .pad_i(pad_i), .pad(pad[v]), .conv_a_ch_en(ca[v]),
      .cmp_d_in_en(cd[v]), .conv_c_ch_en(cc[v]), .alt_active(alt[v]),
      .clock_out_select_reg(ckr[v]));
  end

  // ********
  // helpers
  // ********
  always #50 sys_clk = ~sys_clk;

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  function automatic logic [35:0] one(input int p, input pmux_pkg::pmux_sel_t c);
    one = 36'h0;
    one[p*3 +: 3] = c;
  endfunction

  // selection write: alternates settle after one edge, pads after the next
  task automatic wr(input logic [11:0] e, input logic [35:0] s);
    pen = e;
    sel = s;
    cfg_wr = 1'b1;
    step(1);
    cfg_wr = 1'b0;
    step(1);
  endtask

  task automatic wait_rel(output int n);
    n = 0;
    while (dev_rst_n[0] !== 1'b1 && n < 60)
    begin
      step(1);
      n++;
    end
  endtask

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    int n;
    rstn = 1'b1;
    wait_rel(n);
    chk(n, RSTC + 1);
    chk({alt[0], alt[1], per_i[0]}, 36'h0);
    chk({pad[0][0].pu, pad[1][1].pu, pad[0][0].oe, pad[1][1].oe}, 4'hC);
    chk({ca[0], cd[0], cc[0], ca[1], cd[1], cc[1]}, 24'h0);
    $display("test reset done");
  endtask

  task automatic t_gpio();
    gout = 12'hA5C;
    gdir = 12'h3F0;
    pad_i = 12'hC63;
    repeat (2)
    begin
      step(1);
      for (int i = 2; i < 12; i++)
        chk({pad[1][i].o, pad[1][i].oe}, {gout[i], gdir[i]});
      chk(gpio_in[0], pad_i);
      chk(per_i[0].test_clock, 1'b1);
      gdir = ~gdir;
    end
    $display("test gpio done");
  endtask

  task automatic t_select();
    wr(12'h000, one(pmux_pkg::PIN_C1, pmux_pkg::FN_CRYSTAL));
    chk(alt[0], 12'h000);
    wr(12'h008, 36'h0);
    chk(alt[0], 12'h000);
    wr(12'h008, one(pmux_pkg::PIN_C1, pmux_pkg::FN_CRYSTAL));
    chk(alt[1], 12'h008);
    chk({pad[0][3].o, pad[0][3].oe}, 2'h1);
    $display("test select done");
  endtask

  task automatic t_clock_out();
    clk_src = 8'h20;
    cks = 3'h5;
    cko_wr = 1'b1;
    step(1);
    cko_wr = 1'b0;
    wr(12'h010, one(pmux_pkg::PIN_C2, pmux_pkg::FN_C2_CKOUT));
    chk({ckr[0], pad[0][4].o, pad[0][4].oe}, {3'h5, 2'h3});
    cks = 3'h4;
    cko_wr = 1'b1;
    step(1);
    cko_wr = 1'b0;
    step(1);
    chk({ckr[1], pad[1][4].o}, {3'h4, 1'b0});
    $display("test clock out done");
  endtask

  task automatic t_serial();
    per_o.serial0_tx = 1'b1;
    per_o.xbar_out11 = 1'b1;
    wr(12'h010, one(pmux_pkg::PIN_C2, pmux_pkg::FN_C2_TX));
    chk({pad[0][4].o, pad[0][4].oe}, 2'h3);
    sw1 = 1'b1;
    pad_i[4] = 1'b1;
    step(2);
    chk({pad[0][4].oe, per_i[0].serial0_rx}, 2'h1);
    sw1 = 1'b0;
    wr(12'h010, one(pmux_pkg::PIN_C2, pmux_pkg::FN_C2_XB_TB));
    chk({pad[0][4].o, pad[1][4].o}, 2'h2);
    per_o.xbar_out11 = 1'b0;
    per_o.timer_b0_o = 1'b1;
    step(1);
    chk({pad[0][4].o, pad[1][4].o}, 2'h1);
    $display("test serial done");
  endtask

  task automatic t_analog();
    wr(12'hF00, {12'h249, 24'h0});
    chk({ca[0], cd[0], cc[0]}, 12'hFF0);
    chk({ca[1], cd[1], cc[1]}, 12'hF1F);
    chk(pad[0][8].ana, 1'b1);
    $display("test analog done");
  endtask

  // clock, comparator, watchdog, crystal, receive, timer and crossbar codes of C0, F8, C3 and C4
  task automatic t_inputs();
    per_o.cmp_d_o = 1'b1;
    pad_i = 12'h0E6;
    wr(12'h0E4, one(pmux_pkg::PIN_C0, pmux_pkg::FN_CLKIN) | one(pmux_pkg::PIN_F8,
      pmux_pkg::FN_F8_CMPD) | one(pmux_pkg::PIN_C3, pmux_pkg::FN_C3_CLKIN1)
      | one(pmux_pkg::PIN_C4, pmux_pkg::FN_C4_WDOG));
    chk({per_i[0].ext_clock_in0, per_i[0].ext_clock_in1, pad[1][5].o, pad[1][5].oe,
      pad[1][7].o, pad[1][7].oe}, 6'h3D);
    wr(12'h0E4, one(pmux_pkg::PIN_C0, pmux_pkg::FN_CRYSTAL) | one(pmux_pkg::PIN_F8,
      pmux_pkg::FN_F8_RX) | one(pmux_pkg::PIN_C3, pmux_pkg::FN_C3_TA0)
      | one(pmux_pkg::PIN_C4, pmux_pkg::FN_C4_XBIN));
    chk({per_i[0].crystal_in, per_i[0].serial0_rx, per_i[0].timer_a0_i, per_i[0].xbar_in_c4,
      per_i[0].ext_clock_in0}, 5'h1E);
    $display("test inputs done");
  endtask

  task automatic t_reset_pin();
    int n;
    pad_i[1] = 1'b0;
    step(4);
    chk({dev_rst_n[0], alt[0]}, 13'h0);
    pad_i[1] = 1'b1;
    wait_rel(n);
    chk(n, RSTC + 1);
    wr(12'h002, one(pmux_pkg::PIN_RST, pmux_pkg::FN_PORT_D));
    pad_i[1] = 1'b0;
    step(4);
    chk({dev_rst_n[0], alt[0][1]}, 2'h3);
    sw_rst_req = 1'b1;
    pad_i[1] = 1'b1;
    step(1);
    sw_rst_req = 1'b0;
    step(1);
    chk(dev_rst_n[1], 1'b0);
    wait_rel(n);
    chk(alt[0], 12'h000);
    wdog_rst_req = 1'b1;
    step(1);
    wdog_rst_req = 1'b0;
    step(1);
    chk(dev_rst_n[0], 1'b0);
    wait_rel(n);
    chk({dev_rst_n[0], 8'(n)}, {1'b1, 8'(RSTC)});
    $display("test reset pin done");
  endtask

  initial
  begin
    step(20);
    t_reset();
    t_gpio();
    t_select();
    t_clock_out();
    t_serial();
    t_analog();
    t_inputs();
    t_reset_pin();
    complete_run();
  end
endmodule

`default_nettype wire
